/* core/cas_scripter.sv */
// Condition and action scripting engine: table, evaluation and dispatch
// Summary of operation
// - Table holds sixteen entries; configuring beyond sixteen is rejected.
// - Each entry binds one action, launched when its condition turns true.
// - Several entries may share one condition; each launches its own action.
// - Compound condition is the AND of all selected sub-conditions.
// - Role, profile, policy and hardware indication actions run only at pre-init.
// - Packet sends, counters, timers, GPIO and hibernate run at runtime.
// - Increment adds exactly one to the selected counter.
// - Set loads the selected counter with the configured value.
// - Eight user counters of 32 bits each.
// - Eight timers with one-second granularity, nothing finer.
// - Packet payload at most one packet, at most eight tokens.
// - Launch latency varies; no fixed trigger-to-action delay.
`timescale 1ns/10ps
`default_nettype none
module cas_scripter #(
  parameter int SEC_CYCLES = cas_pkg::SEC_CYCLES,
  parameter int PKT_MAX_BYTES = cas_pkg::PKT_MAX_BYTES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cfgValid,
  input wire logic [cas_pkg::IDX_W-1:0] cfgIndex,
  input wire logic cfgEnable,
  input wire logic cfgPreInit,
  input wire logic [cas_pkg::COND_W-1:0] cfgMask,
  input wire cas_pkg::cas_action_t cfgAction,
  input wire logic [cas_pkg::SEL_W-1:0] cfgSel,
  input wire logic [cas_pkg::COUNTER_W-1:0] cfgValue,
  input wire logic [cas_pkg::TOKEN_W-1:0] cfgTokens,
  input wire logic [cas_pkg::LEN_W-1:0] cfgLength,
  output logic cfgAccept,
  output logic cfgReject,
  input wire logic preInitActive,
  input wire logic [cas_pkg::COND_IN_W-1:0] condIn,
  output logic actLaunch,
  output logic [3:0] actEntry,
  output logic actRefused,
  output logic initActValid,
  output cas_pkg::cas_action_t initActKind,
  output logic [cas_pkg::COUNTER_W-1:0] initActValue,
  output logic pktValid,
  input wire logic pktReady,
  output cas_pkg::cas_action_t pktKind,
  output logic [3:0] pktEntry,
  output logic [cas_pkg::TOKEN_W-1:0] pktTokens,
  output logic [cas_pkg::LEN_W-1:0] pktLength,
  output logic [cas_pkg::GPIO_W-1:0] gpioOut,
  output logic hibernateReq,
  input wire logic hibernate_wake_n,
  input wire logic [cas_pkg::SEL_W-1:0] cntSel,
  output logic [cas_pkg::COUNTER_W-1:0] cntValue
);
  localparam int N = cas_pkg::NUM_ENTRIES;
  localparam int NT = cas_pkg::NUM_TIMERS;
  localparam int CW = cas_pkg::COUNTER_W;
  typedef enum logic [0:0] {ST_IDLE, ST_WAIT_PKT} cas_state_t;

  cas_state_t state_q;
  logic [N-1:0] entValid_q, entPre_q, prevTrue_q, pending_q, pending_d;
  logic [cas_pkg::COND_W-1:0] entMask_q [N];
  cas_pkg::cas_action_t entAct_q [N];
  logic [cas_pkg::SEL_W-1:0] entSel_q [N];
  logic [CW-1:0] entValue_q [N];
  logic [cas_pkg::TOKEN_W-1:0] entTokens_q [N];
  logic [cas_pkg::LEN_W-1:0] entLen_q [N];
  logic [CW-1:0] cnt_q [cas_pkg::NUM_COUNTERS];
  logic [NT-1:0] tmrFlag_q, tmrExpire, tmrLoad;
  logic [23:0] secDiv_q;
  logic [15:0] evalDiv_q;
  logic [N-1:0] condTrue, newRise;
  logic [3:0] grantIdx;

  ////////////////////////////////////////////////////////////////////////
  // Dividers: one-second tick for timers, evaluation tick for conditions
  wire secTick = (secDiv_q == 24'(SEC_CYCLES - 1));
  wire evalTick = (evalDiv_q == 16'(cas_pkg::EVAL_CYCLES - 1));
  always_ff @(posedge core_clk) begin
    if (reset) begin
      secDiv_q <= '0;
      evalDiv_q <= '0;
    end else begin
      secDiv_q <= secTick ? '0 : secDiv_q + 24'h000001;
      evalDiv_q <= evalTick ? '0 : evalDiv_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration checks: bad index, too many tokens, oversize payload,
  // or a pre-init-only action bound to a runtime condition
  wire cfgPreOnly = (cfgAction inside {cas_pkg::ACT_SET_ROLE, cas_pkg::ACT_DEL_PROFILES,
                     cas_pkg::ACT_CONN_POLICY, cas_pkg::ACT_HW_GPIO_IND});
  wire cfgBad = (cfgIndex >= 5'(N))
             || (cfgTokens > 4'(cas_pkg::MAX_TOKENS))
             || (cfgLength > 16'(PKT_MAX_BYTES))
             || (cfgEnable && cfgPreOnly && !cfgPreInit);
  wire cfgTake = cfgValid && !cfgBad;
  wire [3:0] cfgSlot = cfgIndex[3:0];

  // Table writes; an entry rewritten keeps its previous condition level in prevTrue_q
  always_ff @(posedge core_clk) begin
    if (reset) begin
      entValid_q <= '0;
      entPre_q <= '0;
      cfgAccept <= 1'b0;
      cfgReject <= 1'b0;
      for (int i = 0; i < N; i++) begin
        entMask_q[i] <= '0;
        entAct_q[i] <= cas_pkg::ACT_NONE;
        entSel_q[i] <= '0;
        entValue_q[i] <= '0;
        entTokens_q[i] <= '0;
        entLen_q[i] <= '0;
      end
    end else begin
      cfgAccept <= cfgTake;
      cfgReject <= cfgValid && cfgBad;
      if (cfgTake) begin
        entValid_q[cfgSlot] <= cfgEnable;
        entPre_q[cfgSlot] <= cfgPreInit;
        entMask_q[cfgSlot] <= cfgMask;
        entAct_q[cfgSlot] <= cfgAction;
        entSel_q[cfgSlot] <= cfgSel;
        entValue_q[cfgSlot] <= cfgValue;
        entTokens_q[cfgSlot] <= cfgTokens;
        entLen_q[cfgSlot] <= cfgLength;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Condition vector: timer expiry flags above the external inputs.
  // A flag lives until the next evaluation tick; a new expiry wins.
  wire [cas_pkg::COND_W-1:0] condVec = {tmrFlag_q, condIn};
  always_comb begin
    for (int i = 0; i < N; i++) begin
      condTrue[i] = entValid_q[i] && ((condVec & entMask_q[i]) == entMask_q[i])
                 && (entPre_q[i] ? preInitActive : !preInitActive);
      newRise[i] = evalTick && condTrue[i] && !prevTrue_q[i];
    end
  end

  // Lowest pending entry is served first; shared conditions queue up
  always_comb begin
    grantIdx = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending_q[i]) grantIdx = 4'(i);
    end
  end
  wire doGrant = (state_q == ST_IDLE) && (pending_q != '0) && !hibernateReq;
  wire [N-1:0] grantHot = doGrant ? (N'(1) << grantIdx) : '0;
  assign pending_d = (pending_q & ~grantHot) | newRise;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      prevTrue_q <= '0;
      pending_q <= '0;
      tmrFlag_q <= '0;
    end else begin
      if (evalTick) prevTrue_q <= condTrue;
      pending_q <= pending_d;
      tmrFlag_q <= (tmrFlag_q & ~{NT{evalTick}}) | tmrExpire;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode of the granted entry
  wire cas_pkg::cas_action_t gAct = entAct_q[grantIdx];
  wire [cas_pkg::SEL_W-1:0] gSel = entSel_q[grantIdx];
  wire [CW-1:0] gValue = entValue_q[grantIdx];
  wire [CW-1:0] selCnt = cnt_q[gSel];
  wire gPreOnly = (gAct inside {cas_pkg::ACT_SET_ROLE, cas_pkg::ACT_DEL_PROFILES,
                   cas_pkg::ACT_CONN_POLICY, cas_pkg::ACT_HW_GPIO_IND});
  wire gPkt = (gAct inside {cas_pkg::ACT_SEND_RAW, cas_pkg::ACT_SEND_UDP,
               cas_pkg::ACT_SEND_TCP});
  wire doInc = doGrant && (gAct == cas_pkg::ACT_CNT_INC);
  wire doSet = doGrant && (gAct == cas_pkg::ACT_CNT_SET);
  wire doTmr = doGrant && (gAct == cas_pkg::ACT_TIMER_CTRL);
  assign tmrLoad = doTmr ? (NT'(1) << gSel) : '0;

  // Action execution; packet sends hold until the networking core takes them
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      actLaunch <= 1'b0;
      actEntry <= 4'h0;
      actRefused <= 1'b0;
      initActValid <= 1'b0;
      initActKind <= cas_pkg::ACT_NONE;
      initActValue <= '0;
      pktValid <= 1'b0;
      pktKind <= cas_pkg::ACT_NONE;
      pktEntry <= 4'h0;
      pktTokens <= '0;
      pktLength <= '0;
      gpioOut <= cas_pkg::GPIO_RST;
      hibernateReq <= 1'b0;
      for (int c = 0; c < cas_pkg::NUM_COUNTERS; c++) cnt_q[c] <= cas_pkg::COUNTER_RST;
    end else begin
      actLaunch <= doGrant;
      actRefused <= doGrant && gPreOnly && !preInitActive;
      initActValid <= doGrant && gPreOnly && preInitActive;
      if (doGrant) actEntry <= grantIdx;
      if (doGrant && gPreOnly) begin
        initActKind <= gAct;
        initActValue <= gValue;
      end
      if (doInc) cnt_q[gSel] <= selCnt + 32'h00000001;
      if (doSet) cnt_q[gSel] <= gValue;
      if (doGrant && gAct == cas_pkg::ACT_SET_GPIO) gpioOut[gSel] <= gValue[0];
      // Wake line low ends hibernate and resumes dispatch
      if (!hibernate_wake_n) hibernateReq <= 1'b0;
      else if (doGrant && gAct == cas_pkg::ACT_HIBERNATE) hibernateReq <= 1'b1;
      case (state_q)
        ST_IDLE: begin
          if (doGrant && gPkt) begin
            pktValid <= 1'b1;
            pktKind <= gAct;
            pktEntry <= grantIdx;
            pktTokens <= entTokens_q[grantIdx];
            pktLength <= entLen_q[grantIdx];
            state_q <= ST_WAIT_PKT;
          end
        end
        ST_WAIT_PKT: begin
          if (pktReady) begin
            pktValid <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Counter read-back port
  always_ff @(posedge core_clk) begin
    if (reset) cntValue <= '0;
    else cntValue <= cnt_q[cntSel];
  end

  ////////////////////////////////////////////////////////////////////////
  // Timer bank, one second resolution
  for (genvar t = 0; t < NT; t++) begin : g_tmr
    cas_timer #(.W(cas_pkg::TIMER_W)) u_tmr (
      .core_clk(core_clk),
      .reset(reset),
      .secTick(secTick),
      .load(tmrLoad[t]),
      .period(entValue_q[grantIdx][cas_pkg::TIMER_W-1:0]),
      .expire(tmrExpire[t]),
      .running()
    );
  end

  ////////////////////////////////////////////////////////////////////////
  property p_index_reject;
    @(posedge core_clk) disable iff (reset)
      cfgValid && (cfgIndex >= 5'(cas_pkg::NUM_ENTRIES)) |=> cfgReject && !cfgAccept;
  endproperty
  a_index_reject: assert property (p_index_reject)
    else $error("out of range entry index accepted");

  property p_tokens_reject;
    @(posedge core_clk) disable iff (reset)
      cfgValid && (cfgTokens > 4'(cas_pkg::MAX_TOKENS)) |=> cfgReject;
  endproperty
  a_tokens_reject: assert property (p_tokens_reject)
    else $error("too many packet tokens accepted");

  property p_inc_one;
    @(posedge core_clk) disable iff (reset)
      doInc |=> cnt_q[$past(gSel)] == $past(selCnt) + 32'h00000001;
  endproperty
  a_inc_one: assert property (p_inc_one)
    else $error("increment did not add one");

  property p_set_value;
    @(posedge core_clk) disable iff (reset)
      doSet |=> cnt_q[$past(gSel)] == $past(gValue);
  endproperty
  a_set_value: assert property (p_set_value)
    else $error("set counter did not load value");

  property p_preonly_refused;
    @(posedge core_clk) disable iff (reset)
      doGrant && gPreOnly && !preInitActive |=> actRefused && !initActValid;
  endproperty
  a_preonly_refused: assert property (p_preonly_refused)
    else $error("pre-init action ran at runtime");

  property p_runtime_ok;
    @(posedge core_clk) disable iff (reset)
      doGrant && gPkt |=> pktValid && !actRefused && actLaunch;
  endproperty
  a_runtime_ok: assert property (p_runtime_ok)
    else $error("runtime packet send not launched");

  property p_pkt_hold;
    @(posedge core_clk) disable iff (reset)
      pktValid && !pktReady |=> pktValid && $stable(pktEntry) && $stable(pktTokens);
  endproperty
  a_pkt_hold: assert property (p_pkt_hold)
    else $error("packet request dropped before ready");

  property p_and_only;
    @(posedge core_clk) disable iff (reset)
      (newRise & ~condTrue) == '0 && (newRise == '0 || evalTick);
  endproperty
  a_and_only: assert property (p_and_only)
    else $error("launch without all sub-conditions true");

  property p_edge_once;
    @(posedge core_clk) disable iff (reset)
      (newRise & prevTrue_q) == '0;
  endproperty
  a_edge_once: assert property (p_edge_once)
    else $error("relaunch while condition stayed true");

  property p_wake;
    @(posedge core_clk) disable iff (reset)
      hibernateReq && !hibernate_wake_n |=> !hibernateReq ##1 !hibernateReq || doGrant;
  endproperty
  a_wake: assert property (p_wake)
    else $error("hibernate not released by wake line");
endmodule
`default_nettype wire

/* core/cas_timer.sv */
// One scripter timer with whole-second period and periodic expiry
`timescale 1ns/10ps
`default_nettype none
module cas_timer #(
  parameter int W = cas_pkg::TIMER_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic secTick,
  input wire logic load,
  input wire logic [W-1:0] period,
  output logic expire,
  output logic running
);
  logic [W-1:0] remain_q;
  logic [W-1:0] period_q;
  logic expire_q;
  wire lastSec = (remain_q == W'(1));

  // Load restarts the count; a zero period stops the timer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      remain_q <= '0;
      period_q <= '0;
      expire_q <= 1'b0;
    end else if (load) begin
      remain_q <= period;
      period_q <= period;
      expire_q <= 1'b0;
    end else begin
      expire_q <= running && secTick && lastSec;
      if (running && secTick) begin
        remain_q <= lastSec ? period_q : remain_q - W'(1);
      end
    end
  end

  assign expire = expire_q;
  assign running = (remain_q != '0);

  ////////////////////////////////////////////////////////////////////////
  // Expiry only follows a second tick, never a load
  property p_expire_on_second;
    @(posedge core_clk) disable iff (reset)
      expire |-> $past(secTick) && !$past(load);
  endproperty
  a_expire_on_second: assert property (p_expire_on_second)
    else $error("timer expired without a second tick");
endmodule
`default_nettype wire

/* pkg/cas_pkg.sv */
// Shared constants and types of the condition and action scripting engine
package cas_pkg;
  // Table and resource sizes
  localparam int NUM_ENTRIES = 16;
  localparam int IDX_W = 5;
  localparam int NUM_COUNTERS = 8;
  localparam int NUM_TIMERS = 8;
  localparam int SEL_W = 3;
  localparam int COUNTER_W = 32;
  localparam int COND_IN_W = 8;
  localparam int COND_W = 16;
  localparam int GPIO_W = 8;
  localparam int MAX_TOKENS = 8;
  localparam int TOKEN_W = 4;
  localparam int LEN_W = 16;
  localparam int PKT_MAX_BYTES = 1500;
  localparam int TIMER_W = 16;
  // Reset values
  localparam logic [COUNTER_W-1:0] COUNTER_RST = 32'h00000000;
  localparam logic [GPIO_W-1:0] GPIO_RST = 8'h00;
  // Timing: clock period, timer resolution and evaluation period
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIMER_RES_S = 1;
  localparam int SEC_CYCLES = TIMER_RES_S * (1000000000 / CLK_PERIOD_NS);
  localparam int EVAL_PERIOD_NS = 100000;
  localparam int EVAL_CYCLES = EVAL_PERIOD_NS / CLK_PERIOD_NS;
  // Action kinds; the four after ACT_NONE are allowed only in the pre-init phase
  typedef enum logic [3:0] {
    ACT_NONE,
    ACT_SET_ROLE,
    ACT_DEL_PROFILES,
    ACT_CONN_POLICY,
    ACT_HW_GPIO_IND,
    ACT_SEND_RAW,
    ACT_SEND_UDP,
    ACT_SEND_TCP,
    ACT_CNT_INC,
    ACT_CNT_SET,
    ACT_TIMER_CTRL,
    ACT_SET_GPIO,
    ACT_HIBERNATE
  } cas_action_t;
endpackage

/* tb/cas_net_model.sv */
// Behavioural model of the networking core and host wake line facing the scripter
`timescale 1ns/10ps
`default_nettype none
module cas_net_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic pktValid,
  input wire logic hibernateReq,
  output logic pktReady,
  output logic hibernate_wake_n
);
  logic [2:0] waitQ;
  logic [2:0] sleepQ;

  ////////////////////////////////////////////////////////////////////////
  // Packet sink: ready is a one-cycle pulse, delayed when slow to stall dispatch
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pktReady <= 1'b0;
      waitQ <= 3'h0;
    end else begin
      pktReady <= 1'b0;
      if (pktValid && !pktReady) begin
        if (!slow || waitQ == 3'h3) begin
          pktReady <= 1'b1;
          waitQ <= 3'h0;
        end else begin
          waitQ <= waitQ + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host wake: lets the device sleep a few cycles, then pulls the wake line low
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hibernate_wake_n <= 1'b1;
      sleepQ <= 3'h0;
    end else begin
      hibernate_wake_n <= 1'b1;
      if (hibernateReq && hibernate_wake_n) begin
        sleepQ <= sleepQ + 3'h1;
        if (sleepQ == 3'h5) begin
          hibernate_wake_n <= 1'b0;
          sleepQ <= 3'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking testbench of the condition and action scripting engine
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int PKT_MAX = 64;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic cfgValid = 1'b0;
  logic [cas_pkg::IDX_W-1:0] cfgIndex = '0;
  logic cfgEnable = 1'b1;
  logic cfgPreInit = 1'b0;
  logic [cas_pkg::COND_W-1:0] cfgMask = '0;
  cas_pkg::cas_action_t cfgAction = cas_pkg::ACT_NONE;
  logic [cas_pkg::SEL_W-1:0] cfgSel = '0;
  logic [cas_pkg::COUNTER_W-1:0] cfgValue = '0;
  logic [cas_pkg::TOKEN_W-1:0] cfgTokens = '0;
  logic [cas_pkg::LEN_W-1:0] cfgLength = '0;
  logic preInitActive = 1'b1;
  logic [cas_pkg::COND_IN_W-1:0] condIn = '0;
  logic [cas_pkg::SEL_W-1:0] cntSel = '0;
  logic slow = 1'b1;
  logic cfgAccept, cfgReject, actLaunch, actRefused, initActValid, pktValid, pktReady;
  logic hibernateReq, hibernate_wake_n;
  logic [3:0] actEntry, pktEntry;
  cas_pkg::cas_action_t initActKind, pktKind;
  logic [31:0] initActValue, cntValue, setVal, roleVal, rnd;
  logic [cas_pkg::TOKEN_W-1:0] pktTokens;
  logic [cas_pkg::LEN_W-1:0] pktLength;
  logic [cas_pkg::GPIO_W-1:0] gpioOut;
  int failures = 0;
  int checks = 0;
  int seed = 25;
  logic accExp;
  logic [3:0] entExp;
  logic cfgQ[$];
  logic [3:0] actQ[$];

  // Clock of 100 ns period
  always #50 core_clk = ~core_clk;

  cas_scripter #(.SEC_CYCLES(20), .PKT_MAX_BYTES(PKT_MAX)) uut (
    .core_clk(core_clk), .reset(reset), .cfgValid(cfgValid), .cfgIndex(cfgIndex),
    .cfgEnable(cfgEnable), .cfgPreInit(cfgPreInit), .cfgMask(cfgMask),
    .cfgAction(cfgAction), .cfgSel(cfgSel), .cfgValue(cfgValue), .cfgTokens(cfgTokens),
    .cfgLength(cfgLength), .cfgAccept(cfgAccept), .cfgReject(cfgReject),
    .preInitActive(preInitActive), .condIn(condIn), .actLaunch(actLaunch),
    .actEntry(actEntry), .actRefused(actRefused), .initActValid(initActValid),
    .initActKind(initActKind), .initActValue(initActValue), .pktValid(pktValid),
    .pktReady(pktReady), .pktKind(pktKind), .pktEntry(pktEntry), .pktTokens(pktTokens),
    .pktLength(pktLength), .gpioOut(gpioOut), .hibernateReq(hibernateReq),
    .hibernate_wake_n(hibernate_wake_n), .cntSel(cntSel), .cntValue(cntValue)
  );

  cas_net_model partner (
    .core_clk(core_clk), .reset(reset), .slow(slow), .pktValid(pktValid),
    .hibernateReq(hibernateReq), .pktReady(pktReady), .hibernate_wake_n(hibernate_wake_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Monitor: each answer takes the oldest note off its queue
  always @(posedge core_clk) begin
    if (!reset && (cfgAccept === 1'b1 || cfgReject === 1'b1)) begin
      if (cfgQ.size() == 0) check(32'h1, 32'h0);
      else begin
        accExp = cfgQ.pop_front();
        check({30'h0, cfgAccept, cfgReject}, {30'h0, accExp, !accExp});
      end
    end
    // Only entry 6 is a pre-init action; no scenario expects a refusal at dispatch
    if (!reset && actLaunch === 1'b1) begin
      if (actQ.size() == 0) check(32'h1, 32'h0);
      else begin
        entExp = actQ.pop_front();
        check({28'h0, actEntry}, {28'h0, entExp});
        check({30'h0, actRefused, initActValid}, {30'h0, 1'b0, entExp == 4'h6});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Drivers; config writes run back to back until cfg_end lowers the strobe
  task automatic cfg(input int idx, input logic pre, input logic [15:0] mask,
                     input cas_pkg::cas_action_t act, input int sel, input logic [31:0] val,
                     input int tok, input int len, input logic acc);
    @(posedge core_clk);
    cfgValid <= 1'b1;
    cfgIndex <= idx[cas_pkg::IDX_W-1:0];
    cfgEnable <= 1'b1;
    cfgPreInit <= pre;
    cfgMask <= mask;
    cfgAction <= act;
    cfgSel <= sel[cas_pkg::SEL_W-1:0];
    cfgValue <= val;
    cfgTokens <= tok[cas_pkg::TOKEN_W-1:0];
    cfgLength <= len[cas_pkg::LEN_W-1:0];
    cfgQ.push_back(acc);
  endtask

  task automatic cfg_end();
    @(posedge core_clk);
    cfgValid <= 1'b0;
  endtask

  // Write with random fields; an index above 15 becomes a random out-of-range index
  task automatic cfg_rnd(input int idx, input logic en, input logic acc);
    rnd = $random(seed);
    @(posedge core_clk);
    cfgValid <= 1'b1;
    cfgIndex <= (idx > 15) ? {1'b1, rnd[31:28]} : idx[cas_pkg::IDX_W-1:0];
    cfgEnable <= (idx > 15) ? rnd[30] : en;
    cfgPreInit <= rnd[0];
    cfgMask <= rnd[23:8];
    cfgAction <= cas_pkg::cas_action_t'(rnd[7:4] % 4'hD);
    cfgSel <= rnd[3:1];
    cfgValue <= rnd;
    cfgTokens <= {1'b0, rnd[26:24]};
    cfgLength <= {10'h000, rnd[29:24]};
    cfgQ.push_back(acc);
  endtask

  // Condition levels; the unused top bit carries random noise
  task automatic setc(input logic [6:0] b);
    rnd = $random(seed);
    @(posedge core_clk);
    condIn <= {rnd[0], b};
  endtask

  task automatic ticks(input int n);
    repeat (n * cas_pkg::EVAL_CYCLES) @(posedge core_clk);
  endtask

  task automatic cnt(input int sel, input logic [31:0] exp);
    @(posedge core_clk);
    cntSel <= sel[cas_pkg::SEL_W-1:0];
    repeat (2) @(posedge core_clk);
    #1 check(cntValue, exp);
  endtask

  // Waits for the packet request, or the hibernate request when hib is set
  task automatic wait_for(input logic hib, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((hib ? hibernateReq : pktValid) !== lvl && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    #1 check({31'h0, hib ? hibernateReq : pktValid}, {31'h0, lvl});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    setVal = $random(seed);
    roleVal = $random(seed);
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    // Pre-init phase: only pre-init-only actions bound to that phase are taken
    cfg(6, 1'b1, 16'h0000, cas_pkg::ACT_SET_ROLE, 0, roleVal, 0, 0, 1'b1);
    cfg(11, 1'b0, 16'h0001, cas_pkg::ACT_HW_GPIO_IND, 0, 0, 0, 0, 1'b0);
    cfg_end();
    actQ.push_back(4'h6);
    ticks(2);
    check({28'h0, initActKind}, {28'h0, cas_pkg::ACT_SET_ROLE});
    check(initActValue, roleVal);
    @(posedge core_clk);
    preInitActive <= 1'b0;
    // Runtime table, refused writes mixed in
    cfg_rnd(16, 1'b1, 1'b0);
    cfg(0, 1'b0, 16'h0001, cas_pkg::ACT_CNT_INC, 2, 0, 0, 0, 1'b1);
    // Disabled entry is accepted but must never launch
    cfg_rnd(12, 1'b0, 1'b1);
    cfg(1, 1'b0, 16'h0001, cas_pkg::ACT_CNT_SET, 3, setVal, 0, 0, 1'b1);
    cfg(2, 1'b0, 16'h0006, cas_pkg::ACT_CNT_INC, 4, 0, 0, 0, 1'b1);
    cfg(3, 1'b0, 16'h0008, cas_pkg::ACT_SET_GPIO, 5, 1, 0, 0, 1'b1);
    cfg(4, 1'b0, 16'h0010, cas_pkg::ACT_SEND_UDP, 0, 0, 8, PKT_MAX, 1'b1);
    cfg(9, 1'b0, 16'h0010, cas_pkg::ACT_SEND_TCP, 0, 0, 9, 8, 1'b0);
    cfg(9, 1'b0, 16'h0010, cas_pkg::ACT_SEND_RAW, 0, 0, 1, PKT_MAX + 1, 1'b0);
    cfg(5, 1'b0, 16'h0020, cas_pkg::ACT_HIBERNATE, 0, 0, 0, 0, 1'b1);
    cfg(7, 1'b0, 16'h0040, cas_pkg::ACT_TIMER_CTRL, 1, 1, 0, 0, 1'b1);
    cfg(8, 1'b0, 16'h0200, cas_pkg::ACT_CNT_INC, 6, 0, 0, 0, 1'b1);
    cfg(10, 1'b0, 16'h0001, cas_pkg::ACT_SET_ROLE, 0, 0, 0, 0, 1'b0);
    cfg_end();
    // Shared condition launches both entries, once per rising edge
    actQ.push_back(4'h0);
    actQ.push_back(4'h1);
    setc(7'h01);
    ticks(2);
    cnt(2, 32'h1);
    cnt(3, setVal);
    ticks(1);
    cnt(2, 32'h1);
    setc(7'h00);
    ticks(1);
    actQ.push_back(4'h0);
    actQ.push_back(4'h1);
    setc(7'h01);
    ticks(1);
    cnt(2, 32'h2);
    // Compound condition needs both inputs
    setc(7'h02);
    ticks(1);
    cnt(4, 32'h0);
    actQ.push_back(4'h2);
    setc(7'h06);
    ticks(1);
    cnt(4, 32'h1);
    // GPIO drive, then a packet against a stalling sink
    actQ.push_back(4'h3);
    setc(7'h08);
    ticks(1);
    check({31'h0, gpioOut[5]}, 32'h1);
    // Packet first against a stalling sink, then against a prompt one
    for (int p = 0; p < 2; p++) begin
      slow <= (p == 0);
      actQ.push_back(4'h4);
      setc(7'h10);
      wait_for(1'b0, 1'b1, 3000);
      check({28'h0, pktKind}, {28'h0, cas_pkg::ACT_SEND_UDP});
      check({28'h0, pktEntry}, 32'h4);
      check({28'h0, pktTokens}, 32'h8);
      check({16'h0, pktLength}, PKT_MAX);
      wait_for(1'b0, 1'b0, 20);
      setc(7'h00);
      ticks(1);
    end
    // Hibernate entry and wake by the host
    actQ.push_back(4'h5);
    setc(7'h20);
    wait_for(1'b1, 1'b1, 3000);
    wait_for(1'b1, 1'b0, 20);
    // Timer loaded for one second; its expiry launches the counter entry once
    actQ.push_back(4'h7);
    actQ.push_back(4'h8);
    setc(7'h40);
    ticks(3);
    cnt(6, 32'h1);
    check(actQ.size(), 32'h0);
    check(cfgQ.size(), 32'h0);
    wrap_up();
  end

  // Watchdog sized well beyond the expected run of about 20 ticks
  initial begin
    repeat (60000) @(posedge core_clk);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
